// file: src/dvdc_params.svh
// Constants of the DAC volume and data-path control block.
`ifndef DVDC_PARAMS_SVH
`define DVDC_PARAMS_SVH

// Register offsets on the control port.
`define DVDC_ADDR_MODE 8'h3e
`define DVDC_ADDR_SETUP 8'h3f
`define DVDC_ADDR_VOL 8'h40
`define DVDC_ADDR_LGAIN 8'h41
`define DVDC_ADDR_RGAIN 8'h42
`define DVDC_ADDR_APPL_L 8'h7e
`define DVDC_ADDR_APPL_R 8'h7f

// Reset values.
`define DVDC_RST_MODE 8'h00
`define DVDC_RST_SETUP 8'h14
`define DVDC_RST_VOL 8'h0c
`define DVDC_RST_GAIN 8'h00
`define DVDC_RST_READ 8'h00

// Bit positions of the mode-control register.
`define DVDC_MODE_REC_A 6
`define DVDC_MODE_REC_B 5
`define DVDC_MODE_REC_RUN 4
`define DVDC_MODE_PLAY_A 2
`define DVDC_MODE_PLAY_B 1
`define DVDC_MODE_PLAY_RUN 0

// Fields of the data-path setup register; two-bit fields by their low bit.
`define DVDC_SETUP_LPWR 7
`define DVDC_SETUP_RPWR 6
`define DVDC_SETUP_LSRC 4
`define DVDC_SETUP_RSRC 2
`define DVDC_SETUP_STEP 0

// Fields of the mute and link register.
`define DVDC_VOL_LMUTE 3
`define DVDC_VOL_RMUTE 2
`define DVDC_VOL_LINK 0

// Source, stepping and link codes.
`define DVDC_SRC_OFF 2'h0
`define DVDC_SRC_OWN 2'h1
`define DVDC_SRC_OTHER 2'h2
`define DVDC_STEP_ONE 2'h0
`define DVDC_STEP_TWO 2'h1
`define DVDC_STEP_NONE 2'h2
`define DVDC_LINK_L_FROM_R 2'h1
`define DVDC_LINK_R_FROM_L 2'h2

// Widths, depths and the gain step of 0.5 dB.
`define DVDC_SAMPLE_W 16
`define DVDC_FIFO_DEPTH 32
`define DVDC_GAIN_STEP 8'h01
`define DVDC_ZERO_SAMPLE 16'h0000

`endif

// file: src/dvdc_pkg.sv
// Types shared by the DAC volume and data-path control block.
`include "dvdc_params.svh"

package dvdc_pkg;

    // One stereo sample pair as it enters and leaves the path.
    typedef struct packed {
        logic [`DVDC_SAMPLE_W-1:0] left;
        logic [`DVDC_SAMPLE_W-1:0] right;
    } dvdc_pair_type;

    // Pacing of the gain soft-stepping.
    typedef enum logic [1:0] {
        DVDC_PACE_EVEN = 2'h0,
        DVDC_PACE_ODD = 2'h1
    } dvdc_pace_type;

    // Whole state of the control block.
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] setup;
        logic [7:0] vol;
        logic [7:0] lgain;
        logic [7:0] rgain;
        logic [7:0] appl_l;
        logic [7:0] appl_r;
        dvdc_pace_type pace;
        logic [7:0] rdata;
        logic dac_valid;
        dvdc_pair_type dac;
        logic rec_clr;
        logic play_clr;
    } dvdc_state_type;

endpackage

// file: src/dvdc_fifo.sv
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module dvdc_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Filling side.
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side.
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = DEPTH[AW:0];

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic rdy;
    } dvdc_fifo_state_type;

    dvdc_fifo_state_type st;
    dvdc_fifo_state_type next_st;
    logic push;
    logic pop;

    // Ready is registered, so a full FIFO refuses the very next push.
    assign push = in_valid_i && st.rdy;
    assign pop = out_valid_o && out_ready_i;
    assign in_ready_o = st.rdy;
    assign out_valid_o = (st.cnt != '0);
    assign out_data_o = st.mem[st.rp];

    // Pointer and count update.
    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wp] = in_data_i;
            next_st.wp = st.wp + 1'b1;
        end
        if (pop) begin
            next_st.rp = st.rp + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        next_st.rdy = (next_st.cnt != FULL);
    end

    // State register.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // dvdc_fifo

`default_nettype wire

// file: src/dvdc_top.sv
// DAC volume and data-path control registers with sample routing.
//
// Behaviour
// [R01] Record engine condition bits A and B sit at mode bits 6 and 5.
// [R02] Playback engine condition bits A and B sit at mode bits 2 and 1.
// [R03] Mode bit 4 clear: record counter clears each frame start; set: keeps running.
// [R04] Mode bit 0 clear: playback counter clears each frame start; set: keeps running.
// [R05] Setup bit 7 powers the left DAC up; resets to powered down.
// [R06] Setup bit 6 powers the right DAC up; resets to powered down.
// [R07] Left source: off, left, right, or (L+R)/2; resets to left.
// [R08] Right source: off, right, left, or (L+R)/2; resets to right.
// [R09] Soft-step: one step per sample, per two samples, or immediate.
// [R10] Host never writes the reserved soft-step code 11.
// [R11] Volume bit 3 mutes the left DAC; resets muted.
// [R12] Volume bit 2 mutes the right DAC; resets muted.
// [R13] Link: 01 left uses right gain, 10 right uses left, else independent.
// [R14] Compression active keeps gains independent; host should program link 00.
// [R15] Left gain is signed 8-bit in 0.5 dB steps, resetting to 0 dB.
// [R16] Host never writes gain codes 49 to 127 or -128.
// [R17] Host writes zeros to volume register bits 7 to 4.
// [R18] Right gain uses the same signed 0.5 dB encoding.
// [R19] Soft-stepping moves applied gain one step per interval toward target.
`timescale 1ns/1ps
`default_nettype none

module dvdc_top
    import dvdc_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Register port.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // Incoming samples.
    input wire logic smp_valid_i,
    input wire dvdc_pair_type smp_i,
    output logic smp_ready_o,
    // Samples to the DAC channels.
    output logic dac_valid_o,
    output dvdc_pair_type dac_o,
    input wire logic dac_ready_i,
    // Gains and power to the DAC channels.
    output logic [7:0] gain_l_o,
    output logic [7:0] gain_r_o,
    output logic pwr_l_o,
    output logic pwr_r_o,
    // Compression status from the playback path.
    input wire logic drc_active_i,
    // Processing engines.
    input wire logic frame_start_i,
    output logic rec_cond_a_o,
    output logic rec_cond_b_o,
    output logic play_cond_a_o,
    output logic play_cond_b_o,
    output logic rec_ctr_clear_o,
    output logic play_ctr_clear_o
);
    dvdc_state_type st;
    dvdc_state_type next_st;
    logic fifo_valid;
    logic fifo_ready;
    dvdc_pair_type fifo_data;
    logic pop;
    logic [7:0] tgt_l;
    logic [7:0] tgt_r;
    logic [1:0] link;
    logic do_step;

    // Moves a gain one 0.5 dB step toward its target, signed.
    function automatic logic [7:0] dvdc_step(input logic [7:0] cur, input logic [7:0] tgt);
        logic [7:0] res;
        res = cur;
        if ($signed(cur) < $signed(tgt)) begin
            res = cur + `DVDC_GAIN_STEP;
        end else if ($signed(cur) > $signed(tgt)) begin
            res = cur - `DVDC_GAIN_STEP;
        end
        return res;
    endfunction

    // Picks a channel's source; the average keeps a sign bit so it cannot wrap.
    function automatic logic [`DVDC_SAMPLE_W-1:0] dvdc_route(
        input logic [1:0] sel,
        input logic [`DVDC_SAMPLE_W-1:0] own,
        input logic [`DVDC_SAMPLE_W-1:0] other
    );
        logic [`DVDC_SAMPLE_W:0] sum;
        logic [`DVDC_SAMPLE_W-1:0] res;
        sum = {own[`DVDC_SAMPLE_W-1], own} + {other[`DVDC_SAMPLE_W-1], other};
        case (sel)
            `DVDC_SRC_OFF: res = `DVDC_ZERO_SAMPLE;
            `DVDC_SRC_OWN: res = own;
            `DVDC_SRC_OTHER: res = other;
            default: res = sum[`DVDC_SAMPLE_W:1];
        endcase
        return res;
    endfunction

    // The FIFO decouples the sample source from a stalling DAC.
    dvdc_fifo #(
        .WIDTH($bits(dvdc_pair_type)),
        .DEPTH(`DVDC_FIFO_DEPTH)
    ) u_fifo (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .in_valid_i(smp_valid_i),
        .in_data_i(smp_i),
        .in_ready_o(smp_ready_o),
        .out_valid_o(fifo_valid),
        .out_data_o(fifo_data),
        .out_ready_i(fifo_ready)
    );

    // A sample is taken when the output slot is empty or being drained.
    assign fifo_ready = !st.dac_valid || dac_ready_i;
    assign pop = fifo_valid && fifo_ready;

    // Gain targets; compression overrides any link setting.
    assign link = st.vol[`DVDC_VOL_LINK +: 2];
    always_comb begin
        tgt_l = st.lgain;
        tgt_r = st.rgain;
        if (!drc_active_i && link == `DVDC_LINK_L_FROM_R) begin
            tgt_l = st.rgain; // R13
        end
        if (!drc_active_i && link == `DVDC_LINK_R_FROM_L) begin
            tgt_r = st.lgain; // R13
        end
    end // R14

    // Each taken sample is one sample period for the stepping pace.
    assign do_step = pop && (st.setup[`DVDC_SETUP_STEP +: 2] == `DVDC_STEP_ONE
        || (st.setup[`DVDC_SETUP_STEP +: 2] == `DVDC_STEP_TWO && st.pace == DVDC_PACE_ODD)); // R09

    // Next state of the whole block.
    always_comb begin
        next_st = st;
        next_st.rec_clr = frame_start_i && !st.mode[`DVDC_MODE_REC_RUN]; // R03
        next_st.play_clr = frame_start_i && !st.mode[`DVDC_MODE_PLAY_RUN]; // R04
        // Register writes; reserved bits store what the host wrote.
        if (reg_wr_i) begin
            case (reg_addr_i)
                `DVDC_ADDR_MODE: next_st.mode = reg_wdata_i; // R01 R02
                `DVDC_ADDR_SETUP: next_st.setup = reg_wdata_i;
                `DVDC_ADDR_VOL: next_st.vol = reg_wdata_i;
                `DVDC_ADDR_LGAIN: next_st.lgain = reg_wdata_i; // R15
                `DVDC_ADDR_RGAIN: next_st.rgain = reg_wdata_i; // R18
                default: begin
                end
            endcase
        end
        // Register reads answer one cycle later; unmapped reads give zero.
        if (reg_rd_i) begin
            case (reg_addr_i)
                `DVDC_ADDR_MODE: next_st.rdata = st.mode;
                `DVDC_ADDR_SETUP: next_st.rdata = st.setup;
                `DVDC_ADDR_VOL: next_st.rdata = st.vol;
                `DVDC_ADDR_LGAIN: next_st.rdata = st.lgain;
                `DVDC_ADDR_RGAIN: next_st.rdata = st.rgain;
                `DVDC_ADDR_APPL_L: next_st.rdata = st.appl_l;
                `DVDC_ADDR_APPL_R: next_st.rdata = st.appl_r;
                default: next_st.rdata = `DVDC_RST_READ;
            endcase
        end
        // Gain application: immediate, or stepped every one or two sample periods.
        case (st.setup[`DVDC_SETUP_STEP +: 2])
            `DVDC_STEP_ONE, `DVDC_STEP_TWO: begin
                if (do_step) begin
                    next_st.appl_l = dvdc_step(st.appl_l, tgt_l); // R19
                    next_st.appl_r = dvdc_step(st.appl_r, tgt_r); // R19
                end
            end
            default: begin
                next_st.appl_l = tgt_l; // R09
                next_st.appl_r = tgt_r; // R09
            end
        endcase
        // Pace toggles per sample so the two-period mode steps every other one.
        if (pop) begin
            case (st.pace)
                DVDC_PACE_EVEN: next_st.pace = DVDC_PACE_ODD;
                DVDC_PACE_ODD: next_st.pace = DVDC_PACE_EVEN;
                default: next_st.pace = DVDC_PACE_EVEN;
            endcase
        end
        // Output slot: routing, then mute and power gate the channel to zero.
        if (pop) begin
            next_st.dac_valid = 1'b1;
            next_st.dac.left = dvdc_route(st.setup[`DVDC_SETUP_LSRC +: 2], fifo_data.left,
                fifo_data.right); // R07
            next_st.dac.right = dvdc_route(st.setup[`DVDC_SETUP_RSRC +: 2], fifo_data.right,
                fifo_data.left); // R08
            if (!st.setup[`DVDC_SETUP_LPWR] || st.vol[`DVDC_VOL_LMUTE]) begin
                next_st.dac.left = `DVDC_ZERO_SAMPLE; // R05 R11
            end
            if (!st.setup[`DVDC_SETUP_RPWR] || st.vol[`DVDC_VOL_RMUTE]) begin
                next_st.dac.right = `DVDC_ZERO_SAMPLE; // R06 R12
            end
        end else if (dac_ready_i) begin
            next_st.dac_valid = 1'b0;
        end
    end

    // State register with documented reset values.
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.mode <= `DVDC_RST_MODE;
            st.setup <= `DVDC_RST_SETUP; // R05 R06 R07 R08
            st.vol <= `DVDC_RST_VOL; // R11 R12
            st.lgain <= `DVDC_RST_GAIN; // R15
            st.rgain <= `DVDC_RST_GAIN;
            st.appl_l <= `DVDC_RST_GAIN;
            st.appl_r <= `DVDC_RST_GAIN;
            st.pace <= DVDC_PACE_EVEN;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register.
    assign reg_rdata_o = st.rdata;
    assign dac_valid_o = st.dac_valid;
    assign dac_o = st.dac;
    assign gain_l_o = st.appl_l;
    assign gain_r_o = st.appl_r;
    assign pwr_l_o = st.setup[`DVDC_SETUP_LPWR]; // R05
    assign pwr_r_o = st.setup[`DVDC_SETUP_RPWR]; // R06
    assign rec_cond_a_o = st.mode[`DVDC_MODE_REC_A]; // R01
    assign rec_cond_b_o = st.mode[`DVDC_MODE_REC_B]; // R01
    assign play_cond_a_o = st.mode[`DVDC_MODE_PLAY_A]; // R02
    assign play_cond_b_o = st.mode[`DVDC_MODE_PLAY_B]; // R02
    assign rec_ctr_clear_o = st.rec_clr;
    assign play_ctr_clear_o = st.play_clr;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    sequence s_mode_write;
        reg_wr_i && reg_addr_i == `DVDC_ADDR_MODE;
    endsequence

    sequence s_stepped_pop;
        pop && st.setup[`DVDC_SETUP_STEP +: 2] == `DVDC_STEP_ONE && st.appl_l != tgt_l;
    endsequence

    a_rec_cond_bits: assert property (s_mode_write |=> // R01
        rec_cond_a_o == $past(reg_wdata_i[6]) && rec_cond_b_o == $past(reg_wdata_i[5]))
        else $error("record condition bits not taken from write");
    a_play_cond_bits: assert property (s_mode_write |=> // R02
        play_cond_a_o == $past(reg_wdata_i[2]) && play_cond_b_o == $past(reg_wdata_i[1]))
        else $error("playback condition bits not taken from write");
    a_rec_ctr_clear: assert property (frame_start_i |=> // R03
        rec_ctr_clear_o == !$past(st.mode[4]))
        else $error("record counter clear wrong at frame start");
    a_play_ctr_clear: assert property ((frame_start_i && st.mode[0]) |=> // R04
        !play_ctr_clear_o ##0 $past(frame_start_i))
        else $error("playback counter cleared while running mode set");
    a_left_gate: assert property ((pop && (!st.setup[7] || st.vol[3])) |=> // R05
        dac_valid_o && dac_o.left == 16'h0000)
        else $error("left channel not silenced while off or muted");
    a_right_gate: assert property ((pop && (!st.setup[6] || st.vol[2])) |=> // R12
        dac_valid_o && dac_o.right == 16'h0000)
        else $error("right channel not silenced while off or muted");
    a_left_average: assert property ((pop && st.setup[5:4] == 2'h3 && st.setup[7] && !st.vol[3]) |=> // R07
        $signed(dac_o.left) == 16'((17'($signed($past(fifo_data.left)))
            + 17'($signed($past(fifo_data.right)))) >>> 1))
        else $error("left average routing wrong");
    a_right_swap: assert property ((pop && st.setup[3:2] == 2'h2 && st.setup[6] && !st.vol[2]) |=> // R08
        dac_o.right == $past(fifo_data.left))
        else $error("right channel not fed from left input");
    a_step_immediate: assert property ((st.setup[1:0] == 2'h2) |=> // R09
        gain_l_o == $past(tgt_l) && gain_r_o == $past(tgt_r))
        else $error("immediate gain not applied");
    a_step_single: assert property (s_stepped_pop |=> // R19
        (gain_l_o == $past(gain_l_o) + 8'h01) || (gain_l_o == $past(gain_l_o) - 8'h01))
        else $error("soft step not one code");
    a_link_drc: assert property (drc_active_i |-> tgt_l == st.lgain && tgt_r == st.rgain) // R14
        else $error("link applied during compression");
endmodule // dvdc_top

`default_nettype wire

// file: verif/dvdc_sink.sv
// DAC-side sink model that accepts routed samples, with stalls on demand.
`timescale 1ns/1ps
`default_nettype none

module dvdc_sink
    import dvdc_pkg::*;
(
    // Clock and reset.
    input wire logic clock_i,
    input wire logic rst_i,
    // Sample stream from the block.
    input wire logic valid_i,
    input wire dvdc_pair_type data_i,
    output logic ready_o,
    // Control from and report to the bench.
    input wire logic stall_i,
    output logic got_o,
    output dvdc_pair_type word_o
);
    logic [7:0] lfsr;

    // Ready moves only at the falling edge and drops now and then, like a slow converter.
    always @(negedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            ready_o <= 1'b0;
            lfsr <= 8'h5a;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
            ready_o <= !stall_i && (lfsr[1:0] != 2'h0);
        end
    end

    // Each accepted word is reported for one cycle.
    always @(posedge clock_i) begin
        got_o <= valid_i && ready_o;
        word_o <= data_i;
    end
endmodule // dvdc_sink
`default_nettype wire

// file: verif/dac_volume_datapath_control_bench.sv
// Self-checking bench for the DAC volume and data-path control block.
`timescale 1ns/1ps
`default_nettype none

module dac_volume_datapath_control_bench;
    import dvdc_pkg::*;
    logic clock_i, rst_i, reg_wr, reg_rd, smp_valid, dac_ready, drc, frame, stall, got, ok;
    logic rec_a, rec_b, play_a, play_b, rec_clr, play_clr, pwr_l, pwr_r, smp_ready, dac_valid;
    logic [7:0] addr, wdata, rdata, gain_l, gain_r, cfg, vol, mode;
    logic [31:0] seed;
    dvdc_pair_type smp, dac, word, d;
    dvdc_pair_type expq[$];
    int miscompares, num_checks, i, k, count;

    dvdc_top dut_u (.clock_i(clock_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .smp_valid_i(smp_valid),
        .smp_i(smp), .smp_ready_o(smp_ready), .dac_valid_o(dac_valid), .dac_o(dac),
        .dac_ready_i(dac_ready), .gain_l_o(gain_l), .gain_r_o(gain_r), .pwr_l_o(pwr_l),
        .pwr_r_o(pwr_r), .drc_active_i(drc), .frame_start_i(frame), .rec_cond_a_o(rec_a),
        .rec_cond_b_o(rec_b), .play_cond_a_o(play_a), .play_cond_b_o(play_b),
        .rec_ctr_clear_o(rec_clr), .play_ctr_clear_o(play_clr));

    dvdc_sink sink_u (.clock_i(clock_i), .rst_i(rst_i), .valid_i(dac_valid), .data_i(dac),
        .ready_o(dac_ready), .stall_i(stall), .got_o(got), .word_o(word));

    // Shift register for repeatable random values.
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // One channel as the converter should see it; samples are signed, and the wider sum cannot wrap.
    function automatic logic [15:0] route(input logic [1:0] sel, input logic [15:0] own,
        input logic [15:0] oth, input logic on);
        logic [16:0] sum;
        sum = {own[15], own} + {oth[15], oth};
        if (!on)
            return 16'h0000;
        case (sel)
            2'h1: return own;
            2'h2: return oth;
            2'h3: return sum[16:1];
            default: return 16'h0000;
        endcase
    endfunction

    task automatic check(input logic [15:0] got_v, input logic [15:0] exp_v, input string what);
        num_checks++;
        if (got_v !== exp_v) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got_v, exp_v);
        end
    endtask

    // Register accesses leave one idle cycle so a strobe is never lowered and raised at once.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        wdata = v;
        reg_wr = 1'b1;
        @(negedge clock_i);
        reg_wr = 1'b0;
        @(negedge clock_i);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] v);
        addr = a;
        reg_rd = 1'b1;
        @(negedge clock_i);
        reg_rd = 1'b0;
        check(rdata, v, "read");
        @(negedge clock_i);
    endtask

    // Offers one word and holds it until taken or lim cycles pass; valid stays up for the next word.
    task automatic push(input dvdc_pair_type v, input int lim, output logic taken);
        int n;
        dvdc_pair_type e;
        smp = v;
        smp_valid = 1'b1;
        taken = 1'b0;
        for (n = 0; n < lim && !taken; n++) begin
            taken = smp_ready;
            @(negedge clock_i);
        end
        e.left = route(cfg[5:4], v.left, v.right, cfg[7] & !vol[3]);
        e.right = route(cfg[3:2], v.right, v.left, cfg[6] & !vol[2]);
        if (taken)
            expq.push_back(e);
    endtask

    task automatic drain();
        int n;
        smp_valid = 1'b0;
        for (n = 0; n < 300 && expq.size() != 0; n++)
            @(negedge clock_i);
        check(16'(expq.size()), 16'h0000, "drain");
    endtask

    task automatic close_out();
        $display("checks %0d, mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Every word the sink accepts is compared in order with the expectation.
    always @(negedge clock_i) begin
        if (got === 1'b1) begin
            if (expq.size() == 0) begin
                miscompares++;
                $display("wrong value at %0t: unexpected sample", $time);
            end else begin
                d = expq.pop_front();
                check(word.left, d.left, "left sample");
                check(word.right, d.right, "right sample");
            end
        end
    end

    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end

    // The whole run needs a few hundred cycles; this limit is far above that.
    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    initial begin
        rst_i = 1'b1;
        {reg_wr, reg_rd, smp_valid, drc, frame, stall} = 6'h00;
        addr = 8'h00;
        wdata = 8'h00;
        smp = '0;
        cfg = 8'h14;
        vol = 8'h0c;
        seed = 32'd92292;
        repeat (2) @(negedge clock_i);
        rst_i = 1'b0;
        @(negedge clock_i);
        // Reset values, an unmapped offset and a write to a read-only place.
        rd(8'h3e, 8'h00);
        rd(8'h3f, 8'h14);
        rd(8'h40, 8'h0c);
        rd(8'h41, 8'h00);
        rd(8'h42, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'h7e, 8'h33);
        rd(8'h7e, 8'h00);
        // Condition bits and counter clears for random mode words.
        for (i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            mode = seed[7:0] ^ {4'h0, i[0], 2'h0, i[1]};
            wr(8'h3e, mode);
            rd(8'h3e, mode);
            check({rec_a, rec_b, play_a, play_b}, {mode[6], mode[5], mode[2], mode[1]}, "cond");
            frame = 1'b1;
            @(negedge clock_i);
            frame = 1'b0;
            check({rec_clr, play_clr}, {!mode[4], !mode[0]}, "clear");
            @(negedge clock_i);
            check({rec_clr, play_clr}, 2'h0, "clear end");
        end
        // Immediate gains at both range ends, every link code, with and without compression.
        wr(8'h3f, 8'h16);
        wr(8'h41, 8'h30);
        wr(8'h42, 8'h81);
        for (i = 0; i < 8; i++) begin
            wr(8'h40, {6'h00, i[1:0]});
            drc = i[2];
            repeat (2) @(negedge clock_i);
            check(gain_l, (!drc && i[1:0] == 2'h1) ? 8'h81 : 8'h30, "left gain");
            check(gain_r, (!drc && i[1:0] == 2'h2) ? 8'h30 : 8'h81, "right gain");
        end
        drc = 1'b0;
        // Every source code on both channels, random power and mute, with sink stalls.
        for (i = 0; i < 8; i++) begin
            seed = next_rand(seed);
            cfg = {seed[1:0], i[1:0], i[2:1] ^ 2'h1, 2'h2};
            vol = {4'h0, seed[3:2], 2'h0};
            wr(8'h3f, cfg);
            wr(8'h40, vol);
            check({pwr_l, pwr_r}, cfg[7:6], "power");
            stall = seed[4];
            for (k = 0; k < 6; k++) begin
                seed = next_rand(seed);
                push({seed[15:0], seed[31:16]}, 64, ok);
            end
            stall = 1'b0;
            drain();
        end
        // Soft-stepping: one step per sample, then one per two samples.
        vol = 8'h00;
        wr(8'h40, vol);
        wr(8'h41, 8'h00);
        cfg = 8'hd4;
        wr(8'h3f, cfg);
        wr(8'h41, 8'h03);
        for (k = 0; k < 5; k++) begin
            push('0, 64, ok);
            drain();
            check(gain_l, (k < 3) ? 8'(k + 1) : 8'h03, "step one");
        end
        cfg = 8'hd5;
        wr(8'h3f, cfg);
        wr(8'h41, 8'h07);
        for (k = 0; k < 4; k++) begin
            push('0, 64, ok);
            drain();
        end
        check(gain_l, 8'h05, "step two");
        // Fill the buffer against a stalled sink, then drain it whole.
        stall = 1'b1;
        count = 0;
        for (k = 0; k < 40; k++) begin
            seed = next_rand(seed);
            push({1'b0, seed[14:0], 1'b0, seed[30:16]}, 8, ok);
            if (!ok)
                break;
            count++;
        end
        check(16'(count >= 32 && count <= 33), 16'h0001, "fill");
        stall = 1'b0;
        drain();
        close_out();
    end
endmodule // dac_volume_datapath_control_bench
`default_nettype wire
